/* File: verilog/ssp_pkg.sv */
package ssp_pkg;
  // Clock rates
  localparam int unsigned SYS_HZ = 10_000_000;
  localparam int unsigned LNK_HZ = 12_500_000;
  // Frame layout
  localparam int unsigned FRAME_MIN = 10;
  localparam int unsigned FRAME_MAX = 40;
  localparam logic [5:0] FRAME_DEF = 6'h0d;
  localparam logic [5:0] LSB_DEF = 6'h00;
  localparam logic [5:0] MSB_DEF = 6'h0c;
  localparam int unsigned POS_SPAN = 32;
  localparam int unsigned SHIFT_W = FRAME_MAX + 1;
  localparam int unsigned POS_W = 32;
  // Serial clock rates, in kHz, and half periods in link clocks
  localparam int unsigned RATE0_KHZ = 125;
  localparam int unsigned RATE1_KHZ = 250;
  localparam int unsigned RATE2_KHZ = 500;
  localparam int unsigned RATE3_KHZ = 1000;
  localparam int unsigned RATE4_KHZ = 1500;
  localparam int unsigned RATE5_KHZ = 2000;
  localparam logic [5:0] HALF0 = 6'(LNK_HZ / (2 * RATE0_KHZ * 1000));
  localparam logic [5:0] HALF1 = 6'(LNK_HZ / (2 * RATE1_KHZ * 1000));
  localparam logic [5:0] HALF2 = 6'(LNK_HZ / (2 * RATE2_KHZ * 1000));
  localparam logic [5:0] HALF3 = 6'(LNK_HZ / (2 * RATE3_KHZ * 1000));
  localparam logic [5:0] HALF4 = 6'(LNK_HZ / (2 * RATE4_KHZ * 1000));
  localparam logic [5:0] HALF5 = 6'(LNK_HZ / (2 * RATE5_KHZ * 1000));
  // Monoflop gaps, in us, and their counts in link clocks (rounded up)
  localparam int unsigned MONO16_US = 16;
  localparam int unsigned MONO32_US = 32;
  localparam int unsigned MONO48_US = 48;
  localparam int unsigned MONO64_US = 64;
  localparam logic [9:0] GAP16 = 10'((MONO16_US * (LNK_HZ / 1000) + 999) / 1000);
  localparam logic [9:0] GAP32 = 10'((MONO32_US * (LNK_HZ / 1000) + 999) / 1000);
  localparam logic [9:0] GAP48 = 10'((MONO48_US * (LNK_HZ / 1000) + 999) / 1000);
  localparam logic [9:0] GAP64 = 10'((MONO64_US * (LNK_HZ / 1000) + 999) / 1000);
  // Input delays, in us, and their counts in system clocks
  localparam int unsigned DLY_W = 18;
  localparam int unsigned DLY1_US = 50;
  localparam int unsigned DLY2_US = 100;
  localparam int unsigned DLY3_US = 400;
  localparam int unsigned DLY4_US = 800;
  localparam int unsigned DLY5_US = 1600;
  localparam int unsigned DLY6_US = 3200;
  localparam int unsigned DLY7_US = 12800;
  localparam int unsigned DLY8_US = 20000;
  localparam logic [DLY_W-1:0] DLY1_CYC = DLY_W'((DLY1_US * (SYS_HZ / 1000) + 999) / 1000);
  localparam logic [DLY_W-1:0] DLY2_CYC = DLY_W'((DLY2_US * (SYS_HZ / 1000) + 999) / 1000);
  localparam logic [DLY_W-1:0] DLY3_CYC = DLY_W'((DLY3_US * (SYS_HZ / 1000) + 999) / 1000);
  localparam logic [DLY_W-1:0] DLY4_CYC = DLY_W'((DLY4_US * (SYS_HZ / 1000) + 999) / 1000);
  localparam logic [DLY_W-1:0] DLY5_CYC = DLY_W'((DLY5_US * (SYS_HZ / 1000) + 999) / 1000);
  localparam logic [DLY_W-1:0] DLY6_CYC = DLY_W'((DLY6_US * (SYS_HZ / 1000) + 999) / 1000);
  localparam logic [DLY_W-1:0] DLY7_CYC = DLY_W'((DLY7_US * (SYS_HZ / 1000) + 999) / 1000);
  localparam logic [DLY_W-1:0] DLY8_CYC = DLY_W'((DLY8_US * (SYS_HZ / 1000) + 999) / 1000);
  // Edge selection codes
  localparam logic [1:0] EDGE_RISE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  // Link sequencer states
  typedef enum logic [2:0] {
    ST_GAP = 3'b001,
    ST_LOW = 3'b010,
    ST_HIGH = 3'b100
  } ssp_lnk_e;
endpackage

/* File: verilog/ssp_in_filter.sv */
`timescale 1ns/1ns
module ssp_in_filter #(
  parameter int unsigned CNT_W = 18
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Raw pin and settings
  input wire logic pin_i,
  input wire logic [CNT_W-1:0] limit_i,
  // Filtered level
  output logic level_o
);
  logic pin_m_ff;
  logic pin_s_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic level_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_m_ff <= 1'b0;
      pin_s_ff <= 1'b0;
    end else begin
      pin_m_ff <= pin_i;
      pin_s_ff <= pin_m_ff;
    end
  end

  // A level must hold past the limit before it is taken; shorter pulses vanish
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      level_ff <= 1'b0;
    end else if (pin_s_ff == level_ff) begin
      cnt_ff <= '0;
    end else if (cnt_ff >= limit_i) begin
      level_ff <= pin_s_ff;
      cnt_ff <= '0;
    end else begin
      cnt_ff <= cnt_ff + 1'b1;
    end
  end

  assign level_o = level_ff;

  chk_filter_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(level_ff) |-> $past(cnt_ff) >= $past(limit_i))
    else $error("filtered level changed before the delay ran out");
endmodule

/* File: verilog/ssp_reader.sv */
`timescale 1ns/1ns
// Functional notes
// - Frame length is configurable from 10 to 40 bits, default 13, parity excluded.
// - With parity on, one extra bit is clocked in each frame.
// - A parity mismatch raises the encoder fault flag.
// - Gray mode (default) converts the position to binary; dual mode passes it.
// - Gray conversion covers only the bits from LSB to MSB of the position.
// - Direction inversion flips only the position field, not the other frame bits.
// - Serial clock rate: 125 kHz default, 250k, 500k, 1M, 1.5M or 2 MHz.
// - Frames are separated by a monoflop gap of 16/32/48/64 us or automatic.
// - Automatic gap follows the encoder; in isochronous use it is 64 us.
// - Position LSB (default 0) lies below MSB, with MSB minus LSB under 32.
// - Position MSB (default 12) lies below the frame length.
// - In capture mode the selected input edge latches the current position.
// - Capture is assigned to only one of the two inputs at a time.
// - Capture works only when the absolute position is the reference.
// - An input without a function reports its filtered level on its flag.
// - Input pulses shorter than the selected delay are suppressed.
// - One input delay setting applies to both inputs.
// - Capture edge is rising (default), falling or both.
// - Once mode latches only the first edge; periodic latches every edge.
module ssp_reader #(
  parameter logic [ssp_pkg::DLY_W-1:0] DLY_800_CYC = ssp_pkg::DLY4_CYC,
  parameter logic [ssp_pkg::DLY_W-1:0] DLY_1600_CYC = ssp_pkg::DLY5_CYC,
  parameter logic [ssp_pkg::DLY_W-1:0] DLY_3200_CYC = ssp_pkg::DLY6_CYC,
  parameter logic [ssp_pkg::DLY_W-1:0] DLY_12800_CYC = ssp_pkg::DLY7_CYC,
  parameter logic [ssp_pkg::DLY_W-1:0] DLY_20000_CYC = ssp_pkg::DLY8_CYC
) (
  // Clocks and reset
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic lnk_clk_i,
  // Encoder link
  output logic ssi_clk_o,
  input wire logic ssi_data_i,
  // Digital inputs
  input wire logic [1:0] di_i,
  // Link configuration
  input wire logic ssi_en_i,
  input wire logic [5:0] frame_len_i,
  input wire logic parity_en_i,
  input wire logic [2:0] rate_sel_i,
  input wire logic [2:0] mono_sel_i,
  input wire logic isochronous_i,
  // Position configuration
  input wire logic gray_code_i,
  input wire logic invert_i,
  input wire logic [5:0] pos_lsb_i,
  input wire logic [5:0] pos_msb_i,
  // Input configuration
  input wire logic abs_ref_mode_i,
  input wire logic capture_en_i,
  input wire logic capture_src_i,
  input wire logic [1:0] edge_sel_i,
  input wire logic capture_once_i,
  input wire logic [3:0] in_delay_sel_i,
  // Status
  output logic [31:0] position_o,
  output logic position_valid_o,
  output logic encoder_fault_flag_o,
  output logic cfg_error_o,
  output logic [31:0] captured_position_o,
  output logic capture_done_o,
  output logic input0_level_flag_o,
  output logic input1_level_flag_o
);
  localparam int unsigned SW = ssp_pkg::SHIFT_W;
  localparam int unsigned CW = 15;

  // ---------------- Link clock domain ----------------
  logic [1:0] lrst_ff;
  logic l_rst;
  logic [CW-1:0] cfg_m_ff;
  logic [CW-1:0] cfg_s_ff;
  logic sdat_m_ff;
  logic sdat_s_ff;
  logic l_en;
  logic [5:0] l_len;
  logic l_par;
  logic [2:0] l_rate;
  logic [2:0] l_mono;
  logic l_iso;
  logic [5:0] nbits;
  logic [5:0] half_lim;
  logic [9:0] gap_lim;
  logic auto_mode;
  logic gap_ok;
  logic go;
  logic half_end;
  logic last_bit;
  ssp_pkg::ssp_lnk_e st_ff;
  logic sclk_ff;
  logic [5:0] half_ff;
  logic [5:0] bit_ff;
  logic [9:0] gap_ff;
  logic [SW-1:0] shift_ff;
  logic [SW-1:0] frame_ff;
  logic done_tgl_ff;
  logic [5:0] rise_cnt_ff;

  // Reset reaches the link side through two flops
  always_ff @(posedge lnk_clk_i) begin
    lrst_ff <= {lrst_ff[0], rst_i};
  end
  assign l_rst = lrst_ff[1];

  // Settings are expected to be static while enabled; each bit is synchronised alone
  always_ff @(posedge lnk_clk_i) begin
    if (l_rst) begin
      cfg_m_ff <= '0;
      cfg_s_ff <= '0;
      sdat_m_ff <= 1'b1;
      sdat_s_ff <= 1'b1;
    end else begin
      cfg_m_ff <= {ssi_en_i, frame_len_i, parity_en_i, rate_sel_i, mono_sel_i, isochronous_i};
      cfg_s_ff <= cfg_m_ff;
      sdat_m_ff <= ssi_data_i;
      sdat_s_ff <= sdat_m_ff;
    end
  end
  assign {l_en, l_len, l_par, l_rate, l_mono, l_iso} = cfg_s_ff;

  assign nbits = l_len + {5'h00, l_par};

  always_comb begin
    case (l_rate)
      3'h1: half_lim = ssp_pkg::HALF1;
      3'h2: half_lim = ssp_pkg::HALF2;
      3'h3: half_lim = ssp_pkg::HALF3;
      3'h4: half_lim = ssp_pkg::HALF4;
      3'h5: half_lim = ssp_pkg::HALF5;
      default: half_lim = ssp_pkg::HALF0;
    endcase
  end

  always_comb begin
    case (l_mono)
      3'h1: gap_lim = ssp_pkg::GAP16;
      3'h2: gap_lim = ssp_pkg::GAP32;
      3'h3: gap_lim = ssp_pkg::GAP48;
      default: gap_lim = ssp_pkg::GAP64;
    endcase
  end

  // Automatic gap: leave once the data line recovers high, never before 16 us nor after 64 us
  assign auto_mode = (l_mono == 3'h0) && !l_iso;
  always_comb begin
    if (auto_mode) begin
      gap_ok = (gap_ff >= ssp_pkg::GAP16 && sdat_s_ff) || (gap_ff >= ssp_pkg::GAP64);
    end else begin
      gap_ok = gap_ff >= gap_lim;
    end
  end

  assign go = (st_ff == ssp_pkg::ST_GAP) && l_en && gap_ok;
  assign half_end = half_ff >= half_lim - 6'h01;
  assign last_bit = bit_ff >= nbits - 6'h01;

  // Frame sequencer: clock high at rest, low then high once per bit
  always_ff @(posedge lnk_clk_i) begin
    if (l_rst) begin
      st_ff <= ssp_pkg::ST_GAP;
      sclk_ff <= 1'b1;
    end else begin
      case (st_ff)
        ssp_pkg::ST_GAP: begin
          if (go) begin
            st_ff <= ssp_pkg::ST_LOW;
            sclk_ff <= 1'b0;
          end
        end
        ssp_pkg::ST_LOW: begin
          if (half_end) begin
            st_ff <= ssp_pkg::ST_HIGH;
            sclk_ff <= 1'b1;
          end
        end
        ssp_pkg::ST_HIGH: begin
          if (half_end && last_bit) begin
            st_ff <= ssp_pkg::ST_GAP;
          end else if (half_end) begin
            st_ff <= ssp_pkg::ST_LOW;
            sclk_ff <= 1'b0;
          end
        end
        default: begin
          st_ff <= ssp_pkg::ST_GAP;
          sclk_ff <= 1'b1;
        end
      endcase
    end
  end
  assign ssi_clk_o = sclk_ff;

  always_ff @(posedge lnk_clk_i) begin
    if (l_rst || st_ff == ssp_pkg::ST_GAP || half_end) begin
      half_ff <= '0;
    end else begin
      half_ff <= half_ff + 6'h01;
    end
  end

  // Gap counter saturates at the longest gap
  always_ff @(posedge lnk_clk_i) begin
    if (l_rst || st_ff != ssp_pkg::ST_GAP) begin
      gap_ff <= '0;
    end else if (gap_ff < ssp_pkg::GAP64) begin
      gap_ff <= gap_ff + 10'h001;
    end
  end

  // Bits are sampled at the end of the high half, MSB first
  always_ff @(posedge lnk_clk_i) begin
    if (l_rst || go) begin
      bit_ff <= '0;
      shift_ff <= '0;
    end else if (st_ff == ssp_pkg::ST_HIGH && half_end) begin
      bit_ff <= bit_ff + 6'h01;
      shift_ff <= {shift_ff[SW-2:0], sdat_s_ff};
    end
  end

  // Frame word stays put for a whole gap, far longer than the toggle takes to cross
  always_ff @(posedge lnk_clk_i) begin
    if (l_rst) begin
      frame_ff <= '0;
      done_tgl_ff <= 1'b0;
    end else if (st_ff == ssp_pkg::ST_HIGH && half_end && last_bit) begin
      frame_ff <= {shift_ff[SW-2:0], sdat_s_ff};
      done_tgl_ff <= ~done_tgl_ff;
    end
  end

  always_ff @(posedge lnk_clk_i) begin
    if (l_rst || go) begin
      rise_cnt_ff <= '0;
    end else if (st_ff == ssp_pkg::ST_LOW && half_end) begin
      rise_cnt_ff <= rise_cnt_ff + 6'h01;
    end
  end

  chk_frame_bits: assert property (@(posedge lnk_clk_i) disable iff (l_rst)
    (st_ff == ssp_pkg::ST_GAP && $past(st_ff) == ssp_pkg::ST_HIGH) |-> rise_cnt_ff == nbits)
    else $error("frame clocked a wrong number of bits");
  chk_clock_idle: assert property (@(posedge lnk_clk_i) disable iff (l_rst)
    (st_ff == ssp_pkg::ST_GAP) |-> sclk_ff)
    else $error("serial clock not high between frames");
  chk_gap_length: assert property (@(posedge lnk_clk_i) disable iff (l_rst)
    go |-> gap_ff >= (auto_mode ? ssp_pkg::GAP16 : gap_lim))
    else $error("frame started before the monoflop gap elapsed");
  cov_frame_done: cover property (@(posedge lnk_clk_i) disable iff (l_rst)
    st_ff == ssp_pkg::ST_HIGH ##1 st_ff == ssp_pkg::ST_GAP);

  // ---------------- System clock domain ----------------
  logic tg_m_ff;
  logic tg_s_ff;
  logic tg_d_ff;
  logic frame_stb;
  logic [SW-1:0] data_w;
  logic par_bad;
  logic [5:0] span;
  logic [31:0] mask;
  logic [31:0] field;
  logic [31:0] gbin;
  logic [31:0] conv;
  logic [31:0] nxt_pos;
  logic cfg_bad;
  logic [31:0] pos_ff;
  logic pos_vld_ff;
  logic fault_ff;
  logic cfg_err_ff;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tg_m_ff <= 1'b0;
      tg_s_ff <= 1'b0;
      tg_d_ff <= 1'b0;
    end else begin
      tg_m_ff <= done_tgl_ff;
      tg_s_ff <= tg_m_ff;
      tg_d_ff <= tg_s_ff;
    end
  end
  assign frame_stb = tg_s_ff ^ tg_d_ff;

  // Parity bit sits below the frame proper; even parity over frame plus parity
  assign data_w = parity_en_i ? (frame_ff >> 1) : frame_ff;
  assign par_bad = parity_en_i && (^frame_ff);

  assign cfg_bad = (frame_len_i < 6'(ssp_pkg::FRAME_MIN)) || (frame_len_i > 6'(ssp_pkg::FRAME_MAX))
    || (pos_lsb_i >= pos_msb_i) || (span >= 6'(ssp_pkg::POS_SPAN))
    || (pos_msb_i >= frame_len_i);

  assign span = pos_msb_i - pos_lsb_i;
  assign mask = 32'((33'h000000001 << (span + 6'h01)) - 33'h000000001);
  assign field = 32'(data_w >> pos_lsb_i) & mask;

  // Each binary bit is the parity of all field bits at and above it
  for (genvar i = 0; i < 32; i++) begin : g_gray
    assign gbin[i] = ^(field >> i);
  end

  assign conv = gray_code_i ? gbin : field;
  assign nxt_pos = invert_i ? (conv ^ mask) : conv;

  // A frame under an illegal setting is dropped, keeping the last good position
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pos_ff <= '0;
      pos_vld_ff <= 1'b0;
    end else begin
      pos_vld_ff <= frame_stb && !cfg_bad;
      if (frame_stb && !cfg_bad) begin
        pos_ff <= nxt_pos;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fault_ff <= 1'b0;
      cfg_err_ff <= 1'b0;
    end else begin
      cfg_err_ff <= cfg_bad;
      if (frame_stb) begin
        fault_ff <= par_bad;
      end
    end
  end

  assign position_o = pos_ff;
  assign position_valid_o = pos_vld_ff;
  assign encoder_fault_flag_o = fault_ff;
  assign cfg_error_o = cfg_err_ff;

  // ---------------- Digital inputs ----------------
  logic [ssp_pkg::DLY_W-1:0] dly_lim;
  logic [1:0] di_lvl;
  logic cap_on;
  logic src_lvl;
  logic src_prev_ff;
  logic edge_hit;
  logic armed_ff;
  logic cap_fire;
  logic [31:0] cap_ff;
  logic cap_done_ff;
  logic [1:0] flag_ff;

  always_comb begin
    case (in_delay_sel_i)
      4'h0: dly_lim = '0;
      4'h1: dly_lim = ssp_pkg::DLY1_CYC;
      4'h3: dly_lim = ssp_pkg::DLY3_CYC;
      4'h4: dly_lim = DLY_800_CYC;
      4'h5: dly_lim = DLY_1600_CYC;
      4'h6: dly_lim = DLY_3200_CYC;
      4'h7: dly_lim = DLY_12800_CYC;
      4'h8: dly_lim = DLY_20000_CYC;
      default: dly_lim = ssp_pkg::DLY2_CYC;
    endcase
  end

  // Both filters share one limit
  for (genvar i = 0; i < 2; i++) begin : g_di
    ssp_in_filter #(
      .CNT_W(ssp_pkg::DLY_W)
    ) u_flt (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(di_i[i]),
      .limit_i(dly_lim),
      .level_o(di_lvl[i])
    );
  end

  // One source select means capture can never sit on both inputs
  assign cap_on = capture_en_i && abs_ref_mode_i;
  assign src_lvl = di_lvl[capture_src_i];

  always_comb begin
    case (edge_sel_i)
      ssp_pkg::EDGE_FALL: edge_hit = src_prev_ff && !src_lvl;
      ssp_pkg::EDGE_BOTH: edge_hit = src_prev_ff != src_lvl;
      default: edge_hit = !src_prev_ff && src_lvl;
    endcase
  end

  assign cap_fire = cap_on && edge_hit && (armed_ff || !capture_once_i);

  // Switching the source may look like an edge; change it with capture off
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_prev_ff <= 1'b0;
    end else begin
      src_prev_ff <= src_lvl;
    end
  end

  // Once mode rearms only when capture is switched off and on again
  always_ff @(posedge clk_i) begin
    if (rst_i || !cap_on) begin
      armed_ff <= 1'b1;
    end else if (cap_fire && capture_once_i) begin
      armed_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cap_ff <= '0;
      cap_done_ff <= 1'b0;
    end else begin
      cap_done_ff <= cap_fire;
      if (cap_fire) begin
        cap_ff <= pos_ff;
      end
    end
  end

  // An input taken by capture reads zero on its level flag
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flag_ff <= '0;
    end else begin
      flag_ff[0] <= di_lvl[0] && !(cap_on && !capture_src_i);
      flag_ff[1] <= di_lvl[1] && !(cap_on && capture_src_i);
    end
  end

  assign captured_position_o = cap_ff;
  assign capture_done_o = cap_done_ff;
  assign input0_level_flag_o = flag_ff[0];
  assign input1_level_flag_o = flag_ff[1];

  chk_parity_fault: assert property (@(posedge clk_i) disable iff (rst_i)
    frame_stb |=> encoder_fault_flag_o == $past(par_bad))
    else $error("fault flag does not follow the parity check");
  chk_dual_pass: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_stb && !cfg_bad && !gray_code_i && !invert_i) |=> position_o == $past(field))
    else $error("dual code position was altered");
  chk_gray_conv: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_stb && !cfg_bad && gray_code_i && !invert_i)
      |=> ((position_o ^ (position_o >> 1)) == $past(field)))
    else $error("gray conversion gives a wrong binary value");
  chk_invert_field: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_stb && !cfg_bad && !gray_code_i && invert_i) |=> position_o == ($past(field) ^ $past(mask)))
    else $error("inversion reached outside the position field");
  chk_bad_config: assert property (@(posedge clk_i) disable iff (rst_i)
    (frame_stb && cfg_bad) |=> !position_valid_o && $stable(position_o))
    else $error("position updated under an illegal setting");
  chk_capture_latch: assert property (@(posedge clk_i) disable iff (rst_i)
    cap_fire |=> capture_done_o && captured_position_o == $past(pos_ff))
    else $error("capture did not latch the current position");
  chk_capture_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    !abs_ref_mode_i |=> !capture_done_o)
    else $error("capture fired outside absolute reference mode");
  chk_once_only: assert property (@(posedge clk_i) disable iff (rst_i)
    (cap_fire && capture_once_i) ##1 (cap_on && capture_once_i)[*2] |-> !capture_done_o)
    else $error("once mode captured a second edge");
  chk_level_flag: assert property (@(posedge clk_i) disable iff (rst_i)
    !capture_en_i |=> input0_level_flag_o == $past(di_lvl[0]) && input1_level_flag_o == $past(di_lvl[1]))
    else $error("level flag does not follow the filtered input");
  cov_parity_err: cover property (@(posedge clk_i) disable iff (rst_i) frame_stb && par_bad);
  cov_gray_frame: cover property (@(posedge clk_i) disable iff (rst_i) frame_stb && gray_code_i && !cfg_bad);
  cov_capture: cover property (@(posedge clk_i) disable iff (rst_i) cap_fire ##[1:1000] cap_fire);
endmodule

/* File: verification/ssp_enc_model.sv */
`timescale 1ns/1ns
module ssp_enc_model (
  // Serial link
  input wire logic ssi_clk_i,
  output logic data_o,
  // Frame content
  input wire logic [40:0] word_i,
  input wire logic [5:0] nbits_i
);
  int idx = 0;
  time t_last = 0;
  initial data_o = 1'h1;
  // A long high clock marks a new frame; bits leave MSB first on rising edges
  // Line returns high 10 us after the last bit, so the recovery never outlasts a 16 us gap
  always @(posedge ssi_clk_i) begin
    if ($time - t_last > 12000) idx = 0;
    t_last = $time;
    if (idx < nbits_i) data_o <= word_i[nbits_i - 1 - idx];
    if (idx == nbits_i - 1) data_o <= #10000 1'h1;
    idx++;
  end
endmodule

/* File: verification/test_ssi_position_reader_capture.sv */
`timescale 1ns/1ns
module test_ssi_position_reader_capture;
  // Stimulus and observed outputs
  logic clk_i = 0, lnk_clk_i = 0, rst_i = 1, ssi_en_i = 0, parity_en_i = 0, isochronous_i = 0;
  logic gray_code_i = 1, invert_i = 0, abs_ref_mode_i = 0, capture_en_i = 0, capture_src_i = 0, capture_once_i = 0;
  logic [1:0] di_i = '0, edge_sel_i = '0;
  logic [2:0] rate_sel_i = '0, mono_sel_i = '0;
  logic [3:0] in_delay_sel_i = '0;
  logic [5:0] frame_len_i = 6'h0d, pos_lsb_i = 6'h00, pos_msb_i = 6'h0c, nbits = 6'h0d;
  logic [40:0] word = '0;
  logic ssi_clk_o, ssi_data_i, position_valid_o, encoder_fault_flag_o, cfg_error_o, capture_done_o;
  logic input0_level_flag_o, input1_level_flag_o;
  logic [31:0] position_o, captured_position_o, e;
  int n_mismatch = 0, checked = 0, n_cap = 0, khz[6] = '{125, 250, 500, 1000, 1500, 2000};
  time t0;
  ssp_reader i_ssp_reader (.clk_i(clk_i), .rst_i(rst_i), .lnk_clk_i(lnk_clk_i), .ssi_clk_o(ssi_clk_o),
    .ssi_data_i(ssi_data_i), .di_i(di_i), .ssi_en_i(ssi_en_i), .frame_len_i(frame_len_i),
    .parity_en_i(parity_en_i), .rate_sel_i(rate_sel_i), .mono_sel_i(mono_sel_i), .isochronous_i(isochronous_i),
    .gray_code_i(gray_code_i), .invert_i(invert_i), .pos_lsb_i(pos_lsb_i), .pos_msb_i(pos_msb_i),
    .abs_ref_mode_i(abs_ref_mode_i), .capture_en_i(capture_en_i), .capture_src_i(capture_src_i),
    .edge_sel_i(edge_sel_i), .capture_once_i(capture_once_i), .in_delay_sel_i(in_delay_sel_i),
    .position_o(position_o), .position_valid_o(position_valid_o), .encoder_fault_flag_o(encoder_fault_flag_o),
    .cfg_error_o(cfg_error_o), .captured_position_o(captured_position_o), .capture_done_o(capture_done_o),
    .input0_level_flag_o(input0_level_flag_o), .input1_level_flag_o(input1_level_flag_o));
  ssp_enc_model i_ssp_enc_model (.ssi_clk_i(ssi_clk_o), .data_o(ssi_data_i), .word_i(word), .nbits_i(nbits));
  initial forever #50 clk_i = ~clk_i;
  initial begin
    #17;
    forever #40 lnk_clk_i = ~lnk_clk_i;
  end
  // Watchdog bounds every wait on the serial clock
  initial begin
    repeat (90000) @(posedge clk_i);
    n_mismatch++;
    end_sim();
  end
  always @(negedge clk_i) if (capture_done_o === 1'h1) n_cap++;
  task automatic end_sim();
    if (n_mismatch == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(logic ok, string m);
    checked++;
    if (ok !== 1'h1) begin
      n_mismatch++;
      $display("mismatch %0t %s", $time, m);
    end
  endtask
  // Long enough to drain a slow frame, since settings must not move mid-frame
  task automatic pause(int n);
    @(posedge clk_i);
    #5 ssi_en_i = 0;
    repeat (n) @(posedge clk_i);
    #5;
  endtask
  function automatic logic [31:0] exp_pos(logic [40:0] d, int lsb, int msb, int gray, int inv);
    logic [31:0] b;
    b = '0;
    for (int i = msb - lsb; i >= 0; i--) b[i] = d[lsb + i] ^ ((gray != 0 && i < msb - lsb) ? b[i + 1] : 1'h0);
    return inv ? b ^ (32'hffffffff >> (31 - (msb - lsb))) : b;
  endfunction
  task automatic run_case(int len, int lsb, int msb, int par, int bad, int gray, int inv);
    logic [40:0] d;
    pause(1200);
    mono_sel_i = 3'h1;
    isochronous_i = 0;
    d = 41'({$urandom, $urandom}) & ((41'h1 << len) - 1);
    frame_len_i = 6'(len);
    pos_lsb_i = 6'(lsb);
    pos_msb_i = 6'(msb);
    parity_en_i = par[0];
    gray_code_i = gray[0];
    invert_i = inv[0];
    word = par ? {d[39:0], ^d ^ bad[0]} : d;
    nbits = 6'(len + par);
    e = exp_pos(d, lsb, msb, gray, inv);
    ssi_en_i = 1;
    repeat (2) begin
      for (int k = 0; k <= 3000 && position_valid_o !== 1'h1; k++) begin
        if (k == 3000) begin
          chk(1'h0, "no frame result");
          end_sim();
        end
        @(posedge clk_i);
        #1;
      end
      @(posedge clk_i);
      #1;
      chk(position_o === e, "position value");
      chk(encoder_fault_flag_o === 1'(par != 0 && bad != 0), "fault flag");
    end
  endtask
  task automatic cap_try(logic [1:0] es, logic once, logic abs, int exp_n);
    int n0;
    edge_sel_i = es;
    capture_once_i = once;
    abs_ref_mode_i = abs;
    capture_en_i = 0;
    repeat (5) @(posedge clk_i);
    #5 capture_en_i = 1;
    n0 = n_cap;
    repeat (2) begin
      di_i[0] = 1;
      repeat (20) @(posedge clk_i);
      #5 di_i[0] = 0;
      repeat (20) @(posedge clk_i);
      #5;
    end
    chk(n_cap - n0 == exp_n, "capture count");
  endtask
  initial begin
    void'($urandom(92));
    repeat (6) @(posedge clk_i);
    #5 rst_i = 0;
    for (int r = 0; r < 6; r++) begin
      pause(1200);
      rate_sel_i = 3'(r);
      chk(ssi_clk_o === 1'h1, "clock not idle high");
      ssi_en_i = 1;
      @(negedge ssi_clk_o);
      t0 = $time;
      @(posedge ssi_clk_o);
      chk($time - t0 == 80 * (6250 / khz[r]), "serial clock rate");
    end
    for (int m = 1; m < 6; m++) begin
      pause(1200);
      mono_sel_i = (m == 5) ? 3'h0 : 3'(m);
      isochronous_i = (m == 5);
      ssi_en_i = 1;
      do begin
        @(posedge ssi_clk_o);
        t0 = $time;
        @(negedge ssi_clk_o);
      end while ($time - t0 < 2000);
      chk($time - t0 >= 16000 * (m == 5 ? 4 : m) && $time - t0 < 16000 * (m == 5 ? 4 : m) + 1000, "gap");
    end
    run_case(13, 0, 12, 0, 0, 1, 0);
    run_case(10, 2, 9, 1, 0, 0, 1);
    run_case(40, 5, 36, 1, 1, 1, 1);
    run_case(25, 3, 20, 1, 0, 1, 0);
    pause(1200);
    pos_lsb_i = 6'h14;
    ssi_en_i = 1;
    repeat (20) @(posedge clk_i);
    #5 chk(cfg_error_o === 1'h1, "lsb not below msb refused");
    pause(1200);
    pos_lsb_i = 6'h00;
    pos_msb_i = 6'h19;
    ssi_en_i = 1;
    repeat (20) @(posedge clk_i);
    #5 chk(cfg_error_o === 1'h1, "msb at frame length refused");
    cap_try(2'h0, 0, 1, 2);
    chk(captured_position_o === e, "captured_position");
    cap_try(2'h1, 0, 1, 2);
    cap_try(2'h2, 0, 1, 4);
    cap_try(2'h0, 1, 1, 1);
    cap_try(2'h0, 0, 0, 0);
    capture_en_i = 0;
    in_delay_sel_i = 4'h1;
    di_i = 2'h3;
    repeat (300) @(posedge clk_i);
    #5 di_i = 2'h0;
    chk({input1_level_flag_o, input0_level_flag_o} === 2'h0, "short pulse passed");
    repeat (600) @(posedge clk_i);
    #5 di_i = 2'h3;
    repeat (520) @(posedge clk_i);
    #5 chk({input1_level_flag_o, input0_level_flag_o} === 2'h3, "level flags");
    end_sim();
  end
endmodule
